// file: verilog/bcf_pkg.sv
// constants and carrier types for the two-way queue block
// assumes one system clock; port clocks arrive as plain sampled inputs
package bcf_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int DW = 36;
  localparam int AW = 8;
  localparam int CW = 9;
  localparam int OW = 10;
  localparam logic [CW-1:0] DEPTH_CNT = 9'h100;
  localparam logic [OW-1:0] DEPTH_OFS = 10'h100;
  // ************************************************************
  // offset presets and reset values
  // ************************************************************
  localparam logic [OW-1:0] OFS_64 = 10'h040;
  localparam logic [OW-1:0] OFS_16 = 10'h010;
  localparam logic [OW-1:0] OFS_8 = 10'h008;
  localparam logic [OW-1:0] OFS_RST = 10'h040;
  localparam logic [1:0] PROG_LAST = 2'h3;
  localparam logic RST_SPACE = 1'b0;
  localparam logic RST_WORD = 1'b0;
  localparam logic RST_LOW_N = 1'b0;
  localparam logic RST_HIGH_N = 1'b1;
  localparam logic RST_BOX_N = 1'b1;
  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic clk;
    logic sel_n;
    logic dir;
    logic en;
    logic box;
    logic [DW-1:0] data;
  } bcf_pins_t;
  typedef struct packed {
    logic fifo_wr;
    logic fifo_rd;
    logic box_wr;
    logic box_rd;
  } bcf_req_t;
  typedef enum logic [1:0] {PM_IDLE = 2'b00, PM_LOAD = 2'b01, PM_DONE = 2'b11} bcf_prog_t;
endpackage : bcf_pkg

// file: verilog/bcf_top.sv
// two opposite 36-bit queues with mailboxes, port clocks sampled on clk
// assumes port clocks well below clk/4 and port pins stable around edges
// ************************************************************
// Notes on behaviour
// - queue reset clears pointers, flags space/word/low low, high high, mailbox flag high
// - space flag rises two writer-port edges after reset release
// - reset rising edge latches both preset selects for that queue
// - selects 11 give 64, 10 give 16, 01 give 8, 00 program from port A
// - each queue loads presets only from its own reset release
// - first four A-to-B writes load offsets high ab, low ab, high ba, low ba
// - offsets come unsigned from the low port-A data bits
// - after four offsets port-B space flag rises, normal operation begins
// - port-A bus drives only when select and direction are both low
// - port-A write into A-to-B queue on enabled write with space
// - port-A read of B-to-A queue on enabled read with word ready
// - port-B bus drives only when select low and direction high
// - port-B write into B-to-A queue on enabled write with space
// - port-B read of A-to-B queue on enabled read with word ready
// - port-A mailbox write fills A-to-B box; read empties B-to-A box
// - port-B mailbox write fills B-to-A box; read empties A-to-B box
// - while word flag low, next word loads with the edge raising it
// - queue flags pass two stages on their own port clock edges; mailbox flags change in the request cycle
// - low-fill flag high only when count exceeds low offset
// - writes ignored while space flag low
// - reads ignored and output held while word flag low
// ************************************************************
`timescale 1ns/1ps
module bcf_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_queue_ab_n,
  input wire logic reset_queue_ba_n,
  input wire logic preset_sel_lo,
  input wire logic preset_sel_hi,
  input wire bcf_pkg::bcf_pins_t a_port,
  input wire bcf_pkg::bcf_pins_t b_port,
  output logic [bcf_pkg::DW-1:0] a_bus_out,
  output logic a_bus_oe,
  output logic [bcf_pkg::DW-1:0] b_bus_out,
  output logic b_bus_oe,
  output logic a_space_ok,
  output logic b_space_ok,
  output logic a_word_ok,
  output logic b_word_ok,
  output logic a_low_fill_n,
  output logic b_low_fill_n,
  output logic a_high_fill_n,
  output logic b_high_fill_n,
  output logic box_ab_full_n,
  output logic box_ba_full_n
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  bcf_pkg::bcf_pins_t ps1 [2];
  bcf_pkg::bcf_pins_t ps2 [2];
  logic pclk3 [2];
  logic [1:0] rs1, rs2, rs3;
  logic [1:0] fs1, fs2;
  // every pin crosses two flops; third clock stage only feeds edge detect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps1 <= '{default: '0};
      ps2 <= '{default: '0};
      pclk3 <= '{default: 1'b0};
      rs1 <= 2'h0;
      rs2 <= 2'h0;
      rs3 <= 2'h0;
      fs1 <= 2'h0;
      fs2 <= 2'h0;
    end else begin
      ps1[0] <= a_port;
      ps1[1] <= b_port;
      ps2 <= ps1;
      pclk3[0] <= ps2[0].clk;
      pclk3[1] <= ps2[1].clk;
      rs1 <= {reset_queue_ba_n, reset_queue_ab_n};
      rs2 <= rs1;
      rs3 <= rs2;
      fs1 <= {preset_sel_hi, preset_sel_lo};
      fs2 <= fs1;
    end
  end

  // ************************************************************
  // port decode
  // ************************************************************
  function automatic bcf_pkg::bcf_req_t decode(bcf_pkg::bcf_pins_t s, logic edge_seen, logic wr_sense);
    bcf_pkg::bcf_req_t r;
    logic act;
    logic wr;
    act = edge_seen && !s.sel_n && s.en;
    wr = (s.dir == wr_sense);
    r.fifo_wr = act && wr && !s.box;
    r.fifo_rd = act && !wr && !s.box;
    r.box_wr = act && wr && s.box;
    r.box_rd = act && !wr && s.box;
    return r;
  endfunction : decode

  logic pe [2];
  bcf_pkg::bcf_req_t req [2];
  logic qrst [2];
  logic rise [2];
  logic space_ok [2], word_ok [2], low_n [2], high_n [2], mbf_n [2];
  logic [bcf_pkg::CW-1:0] wptr [2], rptr [2];
  logic [bcf_pkg::DW-1:0] outreg [2], box [2];
  logic [bcf_pkg::OW-1:0] lo_off [2], hi_off [2];
  bcf_pkg::bcf_prog_t prog, next_prog;
  logic [1:0] pidx, next_pidx;
  logic prog_wr;

  // port A writes on direction high, port B on direction low
  always_comb begin
    pe[0] = ps2[0].clk && !pclk3[0];
    pe[1] = ps2[1].clk && !pclk3[1];
    req[0] = decode(ps2[0], pe[0], 1'b1);
    req[1] = decode(ps2[1], pe[1], 1'b0);
    qrst[0] = !rs2[0];
    qrst[1] = !rs2[1];
    rise[0] = rs2[0] && !rs3[0];
    rise[1] = rs2[1] && !rs3[1];
  end

  // ************************************************************
  // offset programming through port A
  // ************************************************************
  assign prog_wr = (prog == bcf_pkg::PM_LOAD) && req[0].fifo_wr && space_ok[0];
  // programming starts only from the A-to-B release with both selects low
  always_comb begin
    next_prog = prog;
    next_pidx = pidx;
    if (rise[0]) begin
      next_prog = (fs2 == 2'h0) ? bcf_pkg::PM_LOAD : bcf_pkg::PM_IDLE;
      next_pidx = 2'h0;
    end else if (prog_wr) begin
      next_pidx = pidx + 2'h1;
      if (pidx == bcf_pkg::PROG_LAST) begin
        next_prog = bcf_pkg::PM_DONE;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog <= bcf_pkg::PM_IDLE;
      pidx <= 2'h0;
    end else begin
      prog <= next_prog;
      pidx <= next_pidx;
    end
  end

  // ************************************************************
  // queues: q0 A-to-B (write A, read B), q1 B-to-A
  // ************************************************************
  for (genvar q = 0; q < 2; q++) begin : g_q
    logic [bcf_pkg::DW-1:0] mem [256];
    logic [bcf_pkg::CW-1:0] cnt, cnt_aft, next_wptr, next_rptr;
    logic [bcf_pkg::DW-1:0] next_out;
    logic [bcf_pkg::OW-1:0] next_lo, next_hi, po;
    logic wr, rd, pop, hold, sp1, ne1, lo1, hi1;
    logic next_sp1, next_sp, next_ne1, next_wo, next_lo1, next_low, next_hi1, next_high;
    // programming writes hit offsets, never the array
    assign wr = req[q].fifo_wr && space_ok[q] && !(q == 0 && prog == bcf_pkg::PM_LOAD);
    assign rd = req[1-q].fifo_rd && word_ok[q];
    assign hold = (q == 1) && (prog == bcf_pkg::PM_LOAD);
    assign cnt = wptr[q] - rptr[q];
    assign po = {2'h0, ps2[0].data[7:0]};
    always_comb begin
      // no fall-through while the queue is held in reset, so the output word stays put
      pop = pe[1-q] && (!word_ok[q] || rd) && ne1 && (cnt != '0) && !qrst[q];
      cnt_aft = cnt + {8'h0, wr} - {8'h0, pop};
      next_wptr = wptr[q] + {8'h0, wr};
      next_rptr = rptr[q] + {8'h0, pop};
      next_out = pop ? mem[rptr[q][bcf_pkg::AW-1:0]] : outreg[q];
      next_sp1 = sp1;
      next_sp = space_ok[q];
      next_hi1 = hi1;
      next_high = high_n[q];
      next_ne1 = ne1;
      next_wo = word_ok[q];
      next_lo1 = lo1;
      next_low = low_n[q];
      // writer-side flags: own writes drop space at once, frees seen two edges late
      if (pe[q]) begin
        next_sp1 = (cnt_aft != bcf_pkg::DEPTH_CNT) && !hold;
        next_sp = sp1 && (cnt_aft != bcf_pkg::DEPTH_CNT) && !hold;
        next_hi1 = {1'b0, cnt_aft} < (bcf_pkg::DEPTH_OFS - hi_off[q]);
        next_high = hi1;
      end
      // reader-side flags
      if (pe[1-q]) begin
        next_ne1 = (cnt_aft != '0);
        next_wo = pop ? 1'b1 : (rd ? 1'b0 : word_ok[q]);
        next_lo1 = {1'b0, cnt_aft} > lo_off[q];
        next_low = lo1;
      end
      next_lo = lo_off[q];
      next_hi = hi_off[q];
      if (rise[q]) begin
        case (fs2)
          2'h3: {next_lo, next_hi} = {bcf_pkg::OFS_64, bcf_pkg::OFS_64};
          2'h2: {next_lo, next_hi} = {bcf_pkg::OFS_16, bcf_pkg::OFS_16};
          2'h1: {next_lo, next_hi} = {bcf_pkg::OFS_8, bcf_pkg::OFS_8};
          default: {next_lo, next_hi} = {lo_off[q], hi_off[q]};
        endcase
      end else if (prog_wr) begin
        if (pidx == 2'(2 * q)) next_hi = po;
        if (pidx == 2'(2 * q + 1)) next_lo = po;
      end
    end
    always_ff @(posedge clk) begin
      if (wr) mem[wptr[q][bcf_pkg::AW-1:0]] <= ps2[q].data;
    end
    // queue reset is the synchronised reset pin level
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        wptr[q] <= '0;
        rptr[q] <= '0;
        outreg[q] <= '0;
        {sp1, space_ok[q], ne1, word_ok[q]} <= 4'h0;
        {lo1, low_n[q], hi1, high_n[q]} <= 4'h3;
        lo_off[q] <= bcf_pkg::OFS_RST;
        hi_off[q] <= bcf_pkg::OFS_RST;
      end else begin
        lo_off[q] <= next_lo;
        hi_off[q] <= next_hi;
        outreg[q] <= next_out;
        if (qrst[q]) begin
          wptr[q] <= '0;
          rptr[q] <= '0;
          sp1 <= bcf_pkg::RST_SPACE;
          space_ok[q] <= bcf_pkg::RST_SPACE;
          ne1 <= bcf_pkg::RST_WORD;
          word_ok[q] <= bcf_pkg::RST_WORD;
          lo1 <= bcf_pkg::RST_LOW_N;
          low_n[q] <= bcf_pkg::RST_LOW_N;
          hi1 <= bcf_pkg::RST_HIGH_N;
          high_n[q] <= bcf_pkg::RST_HIGH_N;
        end else begin
          wptr[q] <= next_wptr;
          rptr[q] <= next_rptr;
          sp1 <= next_sp1;
          space_ok[q] <= next_sp;
          ne1 <= next_ne1;
          word_ok[q] <= next_wo;
          lo1 <= next_lo1;
          low_n[q] <= next_low;
          hi1 <= next_hi1;
          high_n[q] <= next_high;
        end
      end
    end

    // ************************************************************
    // mailbox q: written by port q, emptied by port 1-q
    // ************************************************************
    logic [bcf_pkg::DW-1:0] next_box;
    logic next_mbf;
    // a fresh write wins over a same-cycle read of the old mail
    always_comb begin
      next_box = req[q].box_wr ? ps2[q].data : box[q];
      if (qrst[q]) next_mbf = bcf_pkg::RST_BOX_N;
      else if (req[q].box_wr) next_mbf = 1'b0;
      else if (req[1-q].box_rd) next_mbf = 1'b1;
      else next_mbf = mbf_n[q];
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        box[q] <= '0;
        mbf_n[q] <= bcf_pkg::RST_BOX_N;
      end else begin
        box[q] <= next_box;
        mbf_n[q] <= next_mbf;
      end
    end

    a_reset_flags: assert property (@(posedge clk) disable iff (!arst_n) qrst[q] |=>
      !space_ok[q] && !word_ok[q] && !low_n[q] && high_n[q] && mbf_n[q] && wptr[q] == rptr[q])
      else $error("queue reset left a flag or pointer wrong");
    a_flag_on_edge: assert property (@(posedge clk) disable iff (!arst_n)
      !qrst[q] && ($changed(space_ok[q]) || $changed(high_n[q])) |-> $past(pe[q]))
      else $error("writer flag moved without a writer edge");
    a_full_blocks: assert property (@(posedge clk) disable iff (!arst_n)
      !space_ok[q] && !qrst[q] |=> wptr[q] == $past(wptr[q]) || qrst[q])
      else $error("write accepted while space flag low");
    a_fall_through: assert property (@(posedge clk) disable iff (!arst_n)
      !qrst[q] && $rose(word_ok[q]) |-> rptr[q] == $past(rptr[q]) + 9'h1)
      else $error("word flag rose without loading the output register");
    a_empty_holds: assert property (@(posedge clk) disable iff (!arst_n)
      !word_ok[q] ##1 !word_ok[q] |-> $stable(outreg[q]))
      else $error("output register changed while word flag low");
    a_low_fill: assert property (@(posedge clk) disable iff (!arst_n)
      low_n[q] && !qrst[q] |-> {1'b0, cnt} + {9'h0, word_ok[q]} + 10'h1 > lo_off[q])
      else $error("low-fill flag high with too few words");
    a_box_sets: assert property (@(posedge clk) disable iff (!arst_n)
      req[q].box_wr && !qrst[q] |=> !mbf_n[q] && box[q] == $past(ps2[q].data))
      else $error("mailbox write did not store or flag");
    c_box_trip: cover property (@(posedge clk) disable iff (!arst_n) !mbf_n[q] ##[1:200] req[1-q].box_rd);
    c_full: cover property (@(posedge clk) disable iff (!arst_n) cnt == bcf_pkg::DEPTH_CNT);
  end

  // ************************************************************
  // pins and flags out
  // ************************************************************
  // data muxes only between flopped words
  always_comb begin
    a_bus_oe = !ps2[0].sel_n && !ps2[0].dir;
    b_bus_oe = !ps2[1].sel_n && ps2[1].dir;
    a_bus_out = ps2[0].box ? box[1] : outreg[1];
    b_bus_out = ps2[1].box ? box[0] : outreg[0];
    a_space_ok = space_ok[0];
    b_space_ok = space_ok[1];
    b_word_ok = word_ok[0];
    a_word_ok = word_ok[1];
    b_low_fill_n = low_n[0];
    a_low_fill_n = low_n[1];
    a_high_fill_n = high_n[0];
    b_high_fill_n = high_n[1];
    box_ab_full_n = mbf_n[0];
    box_ba_full_n = mbf_n[1];
  end

  a_preset_64: assert property (@(posedge clk) disable iff (!arst_n)
    rise[0] && fs2 == 2'h3 |=> lo_off[0] == bcf_pkg::OFS_64 && hi_off[0] == bcf_pkg::OFS_64)
    else $error("preset 64 not loaded");
  a_prog_hold: assert property (@(posedge clk) disable iff (!arst_n)
    prog == bcf_pkg::PM_LOAD ##1 prog == bcf_pkg::PM_LOAD |-> !space_ok[1])
    else $error("port-B space flag high during programming");
  a_prog_first: assert property (@(posedge clk) disable iff (!arst_n)
    prog_wr && pidx == 2'h0 && !rise[0] |=> hi_off[0] == {2'h0, $past(ps2[0].data[7:0])} && $stable(wptr[0]))
    else $error("first programming write misplaced");
  c_prog_done: cover property (@(posedge clk) disable iff (!arst_n) prog == bcf_pkg::PM_DONE ##[1:200] space_ok[1]);
endmodule : bcf_top

// file: verif/bcf_port_host.sv
// far-side bus master for one port of the two-way queue block
// assumes the bench clock clk; the port clock is made here and runs free
`timescale 1ns/1ps
module bcf_port_host #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic [bcf_pkg::DW-1:0] bus_out,
  input wire logic bus_oe,
  output bcf_pkg::bcf_pins_t pins
);
  logic pclk = 1'b0;
  int cnt = 0;
  logic sel_n = 1'b1;
  logic dir = 1'b0;
  logic en = 1'b0;
  logic box = 1'b0;
  logic [bcf_pkg::DW-1:0] drv = '0;
  // port clock edges land on falling clk edges, away from sampling
  always @(negedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      pclk <= ~pclk;
    end
  end
  // wire level: the device wins while its output enable is up
  assign pins = '{clk: pclk, sel_n: sel_n, dir: dir, en: en, box: box, data: bus_oe ? bus_out : drv};
  // one operation: set up after a falling port edge, held over the rising one
  // an idle port cycle follows, so en never toggles twice in one step
  task automatic op(input logic s_n, input logic d, input logic e, input logic b,
                    input logic [bcf_pkg::DW-1:0] v);
    @(negedge pclk);
    sel_n = s_n;
    dir = d;
    en = e;
    box = b;
    drv = v;
    @(posedge pclk);
    @(negedge pclk);
    en = 1'b0;
    drv = ~v; // released data must not keep its old value
  endtask : op
  // wait some rising port edges
  task automatic edges(input int n);
    repeat (n) @(posedge pclk);
  endtask : edges
endmodule : bcf_port_host

// file: verif/testbench.sv
// self-checking bench for the two-way queue block, one task per test
// assumes bcf_port_host drives each port; depth 256 as in the package
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reset_queue_ab_n = 1'b0;
  logic reset_queue_ba_n = 1'b0;
  logic preset_sel_lo = 1'b1;
  logic preset_sel_hi = 1'b1;
  bcf_pkg::bcf_pins_t a_port;
  bcf_pkg::bcf_pins_t b_port;
  logic [bcf_pkg::DW-1:0] a_bus_out;
  logic [bcf_pkg::DW-1:0] b_bus_out;
  logic a_bus_oe, b_bus_oe, a_space_ok, b_space_ok, a_word_ok, b_word_ok;
  logic a_low_fill_n, b_low_fill_n, a_high_fill_n, b_high_fill_n, box_ab_full_n, box_ba_full_n;
  logic [9:0] flg;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  // ****************************************
  // clock, instances, watchdog
  // ****************************************
  always #20 clk = ~clk;
  assign flg = {a_space_ok, b_space_ok, a_word_ok, b_word_ok, a_low_fill_n, b_low_fill_n,
                a_high_fill_n, b_high_fill_n, box_ab_full_n, box_ba_full_n};
  bcf_top u_bcf_top (.clk(clk), .arst_n(arst_n), .reset_queue_ab_n(reset_queue_ab_n),
    .reset_queue_ba_n(reset_queue_ba_n), .preset_sel_lo(preset_sel_lo), .preset_sel_hi(preset_sel_hi),
    .a_port(a_port), .b_port(b_port), .a_bus_out(a_bus_out), .a_bus_oe(a_bus_oe), .b_bus_out(b_bus_out),
    .b_bus_oe(b_bus_oe), .a_space_ok(a_space_ok), .b_space_ok(b_space_ok), .a_word_ok(a_word_ok),
    .b_word_ok(b_word_ok), .a_low_fill_n(a_low_fill_n), .b_low_fill_n(b_low_fill_n),
    .a_high_fill_n(a_high_fill_n), .b_high_fill_n(b_high_fill_n), .box_ab_full_n(box_ab_full_n),
    .box_ba_full_n(box_ba_full_n));
  // port clocks of different periods, so their phases drift apart
  bcf_port_host u_host_a (.clk(clk), .bus_out(a_bus_out), .bus_oe(a_bus_oe), .pins(a_port));
  bcf_port_host #(.HALF(5)) u_host_b (.clk(clk), .bus_out(b_bus_out), .bus_oe(b_bus_oe), .pins(b_port));
  // run needs some 11000 cycles; a hang is cut off well above that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_word(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  // bounded wait for one flag, then judged
  task automatic wait_flag(input int idx, input logic v, input string what);
    int k;
    k = 0;
    while (flg[idx] !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
    check_bit(what, v, flg[idx]);
  endtask : wait_flag
  // queue reset held across more than four edges of both port clocks
  task automatic qreset(input logic ab, input logic ba, input logic hi, input logic lo);
    @(negedge clk);
    preset_sel_hi = hi;
    preset_sel_lo = lo;
    reset_queue_ab_n = ~ab;
    reset_queue_ba_n = ~ba;
    repeat (48) @(negedge clk);
    if (ab) begin
      check_word("ab reset flags", 36'h3, 36'({a_space_ok, b_word_ok, b_low_fill_n, a_high_fill_n, box_ab_full_n}));
    end
    if (ba) begin
      check_word("ba reset flags", 36'h3, 36'({b_space_ok, a_word_ok, a_low_fill_n, b_high_fill_n, box_ba_full_n}));
    end
    reset_queue_ab_n = 1'b1;
    reset_queue_ba_n = 1'b1;
  endtask : qreset
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // tests
  // ****************************************
  // offsets: ab high 2, ab low 1, ba high 3, ba low 2; upper bits are junk
  task automatic t_program();
    qreset(1'b1, 1'b1, 1'b0, 1'b0);
    wait_flag(9, 1'b1, "a_space_ok");
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'hfffffff02);
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h300000301);
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0000ffe03);
    check_bit("b_space_ok", 1'b0, b_space_ok);
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000202);
    wait_flag(8, 1'b1, "b_space_ok");
    u_host_b.edges(4);
    check_bit("b_word_ok", 1'b0, b_word_ok);
    $display("test program done");
  endtask : t_program
  task automatic t_enables();
    for (int i = 0; i < 4; i++) begin
      u_host_a.op(i[1], i[0], 1'b0, 1'b0, '0);
      u_host_b.op(i[1], i[0], 1'b0, 1'b0, '0);
      repeat (4) @(negedge clk);
      check_bit("a_bus_oe", ~i[1] & ~i[0], a_bus_oe);
      check_bit("b_bus_oe", ~i[1] & i[0], b_bus_oe);
    end
    $display("test enables done");
  endtask : t_enables
  // fill A-to-B until refused, then drain it in order through port B
  task automatic t_fill();
    logic [35:0] q[$];
    int n;
    n = 0;
    u_host_b.op(1'b0, 1'b1, 1'b0, 1'b0, '0);
    while (a_space_ok === 1'b1 && n < 300) begin
      q.push_back(36'h5a0000000 + 36'(n));
      u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, q[n]);
      if (n == 0) begin
        wait_flag(6, 1'b1, "b_word_ok");
        check_word("fall-through", q[0], b_bus_out);
      end
      n++;
    end
    check_bit("capacity", 1'b1, n >= 256);
    check_bit("a_high_fill_n", 1'b0, a_high_fill_n);
    check_bit("b_low_fill_n", 1'b1, b_low_fill_n);
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'hbadbadbad);
    for (int i = 0; i < n; i++) begin
      check_word("b_bus_out", q[i], b_bus_out);
      u_host_b.op(1'b0, 1'b1, 1'b1, 1'b0, '0);
      repeat (2) @(negedge clk);
    end
    wait_flag(6, 1'b0, "b_word_ok");
    u_host_b.op(1'b0, 1'b1, 1'b1, 1'b0, '0);
    check_word("held word", q[n-1], b_bus_out);
    wait_flag(4, 1'b0, "b_low_fill_n");
    $display("test fill done");
  endtask : t_fill
  // B-to-A with low offset 2: three words stay low, a fourth lifts it
  task automatic t_other_way();
    u_host_a.op(1'b0, 1'b0, 1'b0, 1'b0, '0);
    for (int i = 0; i < 4; i++) begin
      u_host_b.op(1'b0, 1'b0, 1'b1, 1'b0, 36'hc00000000 + 36'(i));
      if (i == 2) begin
        u_host_a.edges(4);
        check_bit("a_low_fill_n", 1'b0, a_low_fill_n);
      end
    end
    wait_flag(5, 1'b1, "a_low_fill_n");
    for (int i = 0; i < 4; i++) begin
      check_word("a_bus_out", 36'hc00000000 + 36'(i), a_bus_out);
      u_host_a.op(1'b0, 1'b0, 1'b1, 1'b0, '0);
      repeat (2) @(negedge clk);
    end
    wait_flag(7, 1'b0, "a_word_ok");
    $display("test other way done");
  endtask : t_other_way
  task automatic t_mail();
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h123456789);
    wait_flag(1, 1'b0, "box_ab_full_n");
    u_host_b.op(1'b0, 1'b1, 1'b0, 1'b1, '0);
    check_word("b box data", 36'h123456789, b_bus_out);
    u_host_b.op(1'b0, 1'b1, 1'b1, 1'b1, '0);
    wait_flag(1, 1'b1, "box_ab_full_n");
    u_host_b.op(1'b0, 1'b0, 1'b1, 1'b1, 36'h987654321);
    wait_flag(0, 1'b0, "box_ba_full_n");
    u_host_a.op(1'b0, 1'b0, 1'b0, 1'b1, '0);
    check_word("a box data", 36'h987654321, a_bus_out);
    u_host_a.op(1'b0, 1'b0, 1'b1, 1'b1, '0);
    wait_flag(0, 1'b1, "box_ba_full_n");
    $display("test mail done");
  endtask : t_mail
  // lone A-to-B reset with preset 16, mail and a word left behind, then preset 64
  task automatic t_reset_preset();
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h0000000aa);
    u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0000000bb);
    qreset(1'b1, 1'b0, 1'b1, 1'b0);
    u_host_a.edges(1);
    check_bit("a_space_ok early", 1'b0, a_space_ok);
    check_bit("b_space_ok", 1'b1, b_space_ok);
    wait_flag(9, 1'b1, "a_space_ok");
    for (int i = 0; i < 18; i++) begin
      u_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, 36'(i));
      if (i == 16) begin
        u_host_b.edges(4);
        check_bit("b_low_fill_n at 16", 1'b0, b_low_fill_n);
      end
    end
    wait_flag(4, 1'b1, "b_low_fill_n");
    qreset(1'b1, 1'b0, 1'b1, 1'b1);
    wait_flag(9, 1'b1, "a_space_ok");
    $display("test reset preset done");
  endtask : t_reset_preset
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    t_program();
    t_enables();
    t_fill();
    t_other_way();
    t_mail();
    t_reset_preset();
    print_verdict();
  end
endmodule : testbench
